// File: dma_byp_if.sv
// Link between the bypass/register device end and its supplier
`timescale 1ns/1ns
interface dma_byp_if #(
   parameter int NUM_CH = 4
);
   import dma_byp_pkg::*;
   logic [NUM_CH-1:0] host_to_card_bypass_ready;
   logic [NUM_CH-1:0] host_to_card_bypass_load;
   logic [NUM_CH-1:0][DADDR_W-1:0] host_to_card_bypass_source_address;
   logic [NUM_CH-1:0][DADDR_W-1:0] host_to_card_bypass_dest_address;
   logic [NUM_CH-1:0][LEN_W-1:0] host_to_card_bypass_length;
   logic [NUM_CH-1:0][CTL_W-1:0] host_to_card_bypass_control;
   logic [NUM_CH-1:0] card_to_host_bypass_ready;
   logic [NUM_CH-1:0] card_to_host_bypass_load;
   logic [NUM_CH-1:0][DADDR_W-1:0] card_to_host_bypass_source_address;
   logic [NUM_CH-1:0][DADDR_W-1:0] card_to_host_bypass_dest_address;
   logic [NUM_CH-1:0][LEN_W-1:0] card_to_host_bypass_length;
   logic [NUM_CH-1:0][CTL_W-1:0] card_to_host_bypass_control;
   logic reg_req_valid;
   logic reg_req_bar1;
   logic [ADDR_W-1:0] reg_req_addr;
   logic reg_req_write;
   logic [DATA_W-1:0] reg_req_wdata;
   logic reg_req_ready;
   logic reg_rsp_valid;
   logic [DATA_W-1:0] reg_rsp_rdata;

   modport device (
      output host_to_card_bypass_ready, card_to_host_bypass_ready,
      input host_to_card_bypass_load, host_to_card_bypass_source_address, host_to_card_bypass_dest_address,
      input host_to_card_bypass_length, host_to_card_bypass_control,
      input card_to_host_bypass_load, card_to_host_bypass_source_address, card_to_host_bypass_dest_address,
      input card_to_host_bypass_length, card_to_host_bypass_control,
      input reg_req_valid, reg_req_bar1, reg_req_addr, reg_req_write, reg_req_wdata,
      output reg_req_ready, reg_rsp_valid, reg_rsp_rdata
   );

   modport supplier (
      input host_to_card_bypass_ready, card_to_host_bypass_ready,
      output host_to_card_bypass_load, host_to_card_bypass_source_address, host_to_card_bypass_dest_address,
      output host_to_card_bypass_length, host_to_card_bypass_control,
      output card_to_host_bypass_load, card_to_host_bypass_source_address, card_to_host_bypass_dest_address,
      output card_to_host_bypass_length, card_to_host_bypass_control,
      output reg_req_valid, reg_req_bar1, reg_req_addr, reg_req_write, reg_req_wdata,
      input reg_req_ready, reg_rsp_valid, reg_rsp_rdata
   );
endinterface

// File: dma_byp_pkg.sv
// Shared constants and types for descriptor bypass and register routing
package dma_byp_pkg;
   localparam int MAX_CH = 4;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int DADDR_W = 64;
   localparam int LEN_W = 28;
   localparam int CTL_W = 16;
   localparam int TGT_HI = 15;
   localparam int TGT_LO = 12;
   localparam int CH_HI = 11;
   localparam int CH_LO = 8;
   localparam int OFF_HI = 7;
   localparam int OFF_LO = 0;
   localparam logic [3:0] TGT_HTC = 4'h0;
   localparam logic [3:0] TGT_CTH = 4'h1;
   localparam logic [3:0] TGT_IRQ = 4'h2;
   localparam logic [3:0] TGT_CFG = 4'h3;
   localparam logic [3:0] TGT_HTC_SG = 4'h4;
   localparam logic [3:0] TGT_CTH_SG = 4'h5;
   localparam logic [3:0] TGT_SG_COMMON = 4'h6;
   localparam logic [3:0] TGT_MSIX = 4'h8;
   localparam logic [7:0] OFF_ID = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_CTRL_SET = 8'h08;
   localparam logic [7:0] OFF_CTRL_CLR = 8'h0C;
   localparam logic [7:0] OFF_FLUSH = 8'h14;
   localparam logic [7:0] OFF_STAT = 8'h40;
   localparam logic [7:0] OFF_STAT_RC = 8'h44;
   localparam logic [7:0] OFF_RUN_VEC = 8'h00;
   localparam int CTRL_W = 27;
   localparam logic [CTRL_W-1:0] CTRL_RST = 27'h0000000;
   localparam int RUN_BIT = 0;
   localparam int FLUSH_BIT = 0;
   // Arbitrary identification values
   localparam logic [11:0] ID_CODE = 12'h5A5;
   localparam logic [7:0] ID_VER = 8'h01;

   typedef struct packed {
      logic [DADDR_W-1:0] src;
      logic [DADDR_W-1:0] dst;
      logic [LEN_W-1:0] len;
      logic [CTL_W-1:0] ctl;
   } desc_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_USER = 2'b10
   } host_st_t;

   typedef enum logic [2:0] {
      SP_IDLE = 3'b001,
      SP_REQ = 3'b010,
      SP_WAIT = 3'b100
   } sup_st_t;
endpackage

// File: dma_bypass_device.sv
// Device end: descriptor bypass buffers and register space routing
// Behaviour
// - Per-channel bypass enable vector, bit0 channel0
// - Ready while space; one more after fall
// - No descriptor accepted until Run set
// - Load writes presented fields into buffer
// - Supplier presents 64-bit source and destination
// - Supplier presents 28-bit byte length
// - Supplier presents 16-bit control field
// - First BAR requests go to user master
// - Second BAR requests reach internal registers
// - Internal registers reachable from user slave too
// - Address splits target, channel, byte offset
// - Target codes select the submodule
// - Channel field used only for engine targets
// - Accesses word aligned, low bits zero
// - RW, RO, WO, RC, W1C, W1S supported
// - Each attribute at own offset, aliased bits
// - Undefined bits and addresses are reserved
// - Engine vectors: host-to-card low, card-to-host above
// - Run starts engine; clearing stops delivery at once, buffer kept
`timescale 1ns/1ns
module dma_bypass_device #(
   parameter int NUM_CH = 4,
   parameter int DEPTH = 4,
   parameter logic [3:0] HTC_BYP_EN = 4'hF,
   parameter logic [3:0] CTH_BYP_EN = 4'hF
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   dma_byp_if.device bif,
   output dma_byp_pkg::desc_t eng_desc_o [2*NUM_CH],
   output logic [2*NUM_CH-1:0] eng_desc_valid_o,
   input wire logic [2*NUM_CH-1:0] eng_desc_ready_i,
   output logic [2*NUM_CH-1:0] eng_run_o,
   output logic um_valid_o,
   output logic [dma_byp_pkg::ADDR_W-1:0] um_addr_o,
   output logic um_write_o,
   output logic [dma_byp_pkg::DATA_W-1:0] um_wdata_o,
   input wire logic um_ack_i,
   input wire logic [dma_byp_pkg::DATA_W-1:0] um_rdata_i,
   input wire logic us_valid_i,
   input wire logic [dma_byp_pkg::ADDR_W-1:0] us_addr_i,
   input wire logic us_write_i,
   input wire logic [dma_byp_pkg::DATA_W-1:0] us_wdata_i,
   output logic us_ready_o,
   output logic us_rsp_valid_o,
   output logic [dma_byp_pkg::DATA_W-1:0] us_rdata_o
);
   import dma_byp_pkg::*;

   localparam int ENG = 2*NUM_CH;
   localparam int CNT_W = $clog2(DEPTH+1);
   localparam int PTR_W = $clog2(DEPTH);

   // Engine index hit; also rejects misaligned and stray channel fields
   function automatic logic eng_hit(input logic [ADDR_W-1:0] a, input int e);
      logic [3:0] t;
      logic [3:0] c;
      t = a[TGT_HI:TGT_LO];
      c = a[CH_HI:CH_LO];
      eng_hit = (a[1:0] == 2'b00) &&
         ((t == TGT_HTC && e < NUM_CH && int'(c) == e) ||
          (t == TGT_CTH && e >= NUM_CH && int'(c) == e - NUM_CH));
   endfunction

   host_st_t hst_ff;
   logic host_int;
   logic sel_v;
   logic sel_we;
   logic [ADDR_W-1:0] sel_addr;
   logic [DATA_W-1:0] sel_wdata;
   logic [7:0] sel_off;
   logic [DATA_W-1:0] rd_data;
   logic [ADDR_W-1:0] um_addr_ff;
   logic um_write_ff;
   logic [DATA_W-1:0] um_wdata_ff;
   logic rsp_valid_ff;
   logic [DATA_W-1:0] rsp_rdata_ff;
   logic us_rsp_valid_ff;
   logic [DATA_W-1:0] us_rdata_ff;
   logic [ENG-1:0] byp_en;
   logic [ENG-1:0] ld;
   logic [ENG-1:0] rdy;
   logic [ENG-1:0] loaded_ff;
   logic [ENG-1:0] drop_ff;
   logic [CTRL_W-1:0] ctrl_ff [ENG];
   logic [CNT_W-1:0] cnt_ff [ENG];
   desc_t din [ENG];

   assign byp_en = {CTH_BYP_EN[NUM_CH-1:0], HTC_BYP_EN[NUM_CH-1:0]};
   assign ld = {bif.card_to_host_bypass_load, bif.host_to_card_bypass_load};
   assign bif.host_to_card_bypass_ready = rdy[NUM_CH-1:0];
   assign bif.card_to_host_bypass_ready = rdy[ENG-1:NUM_CH];

   for (genvar c = 0; c < NUM_CH; c++) begin : g_din
      assign din[c] = {bif.host_to_card_bypass_source_address[c], bif.host_to_card_bypass_dest_address[c],
                       bif.host_to_card_bypass_length[c], bif.host_to_card_bypass_control[c]};
      assign din[NUM_CH+c] = {bif.card_to_host_bypass_source_address[c], bif.card_to_host_bypass_dest_address[c],
                              bif.card_to_host_bypass_length[c], bif.card_to_host_bypass_control[c]};
   end

   assign host_int = (hst_ff == HS_IDLE) && bif.reg_req_valid && bif.reg_req_bar1;
   assign bif.reg_req_ready = (hst_ff == HS_IDLE);
   assign us_ready_o = !host_int;
   // user slave shares the internal bus
   assign sel_v = host_int || us_valid_i;
   assign sel_we = host_int ? bif.reg_req_write : us_write_i;
   assign sel_addr = host_int ? bif.reg_req_addr : us_addr_i;
   assign sel_wdata = host_int ? bif.reg_req_wdata : us_wdata_i;
   assign sel_off = sel_addr[OFF_HI:OFF_LO];

   // first BAR forwarded to user master
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hst_ff <= HS_IDLE;
         um_addr_ff <= '0;
         um_write_ff <= 1'b0;
         um_wdata_ff <= '0;
      end else begin
         case (hst_ff)
            HS_IDLE: begin
               if (bif.reg_req_valid && !bif.reg_req_bar1) begin
                  hst_ff <= HS_USER;
                  um_addr_ff <= bif.reg_req_addr;
                  um_write_ff <= bif.reg_req_write;
                  um_wdata_ff <= bif.reg_req_wdata;
               end
            end
            HS_USER: begin
               if (um_ack_i) begin
                  hst_ff <= HS_IDLE;
               end
            end
            default: begin
               hst_ff <= HS_IDLE;
            end
         endcase
      end
   end

   assign um_valid_o = (hst_ff == HS_USER);
   assign um_addr_o = um_addr_ff;
   assign um_write_o = um_write_ff;
   assign um_wdata_o = um_wdata_ff;

   // second BAR answered from internal registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= '0;
         us_rsp_valid_ff <= 1'b0;
         us_rdata_ff <= '0;
      end else begin
         rsp_valid_ff <= host_int || (hst_ff == HS_USER && um_ack_i);
         if (host_int) begin
            rsp_rdata_ff <= sel_we ? '0 : rd_data;
         end else if (hst_ff == HS_USER && um_ack_i) begin
            rsp_rdata_ff <= um_write_ff ? '0 : um_rdata_i;
         end
         us_rsp_valid_ff <= us_valid_i && !host_int;
         if (us_valid_i && !host_int) begin
            us_rdata_ff <= us_write_i ? '0 : rd_data;
         end
      end
   end

   assign bif.reg_rsp_valid = rsp_valid_ff;
   assign bif.reg_rsp_rdata = rsp_rdata_ff;
   assign us_rsp_valid_o = us_rsp_valid_ff;
   assign us_rdata_o = us_rdata_ff;

   always_comb begin
      rd_data = '0;
      // configuration target holds the run vector
      if (sel_addr[TGT_HI:TGT_LO] == TGT_CFG && sel_addr[CH_HI:CH_LO] == 4'h0 && sel_off == OFF_RUN_VEC) begin
         rd_data = DATA_W'(eng_run_o);
      end
      for (int e = 0; e < ENG; e++) begin
         if (eng_hit(sel_addr, e)) begin
            // aliases share the same control or status bits
            case (sel_off)
               OFF_ID: rd_data = {ID_CODE, sel_addr[TGT_HI:TGT_LO], 4'h0, sel_addr[CH_HI:CH_LO], ID_VER};
               OFF_CTRL, OFF_CTRL_SET, OFF_CTRL_CLR: rd_data = DATA_W'(ctrl_ff[e]);
               OFF_STAT, OFF_STAT_RC: rd_data = {16'h0000, 8'(cnt_ff[e]), 6'h00, drop_ff[e], loaded_ff[e]};
               default: rd_data = '0;
            endcase
         end
      end
   end

   for (genvar e = 0; e < ENG; e++) begin : g_eng
      desc_t mem_ff [DEPTH];
      logic [PTR_W-1:0] wptr_ff;
      logic [PTR_W-1:0] rptr_ff;
      logic wr_hit;
      logic rc_hit;
      logic flush;
      logic acc;
      logic pop;

      // channel field only decodes engine targets
      assign wr_hit = sel_v && sel_we && eng_hit(sel_addr, e);
      assign rc_hit = sel_v && !sel_we && eng_hit(sel_addr, e) && sel_off == OFF_STAT_RC;
      assign flush = wr_hit && sel_off == OFF_FLUSH && sel_wdata[FLUSH_BIT];
      assign acc = ld[e] && byp_en[e] && eng_run_o[e] && cnt_ff[e] < CNT_W'(DEPTH);
      assign pop = eng_desc_valid_o[e] && eng_desc_ready_i[e];
      assign rdy[e] = byp_en[e] && eng_run_o[e] && cnt_ff[e] < CNT_W'(DEPTH - 1);
      assign eng_desc_valid_o[e] = eng_run_o[e] && cnt_ff[e] != '0;
      assign eng_desc_o[e] = mem_ff[rptr_ff];
      assign eng_run_o[e] = ctrl_ff[e][RUN_BIT];

      // RW, W1S and W1C control access
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            ctrl_ff[e] <= CTRL_RST;
         end else if (wr_hit) begin
            case (sel_off)
               OFF_CTRL: ctrl_ff[e] <= sel_wdata[CTRL_W-1:0];
               OFF_CTRL_SET: ctrl_ff[e] <= ctrl_ff[e] | sel_wdata[CTRL_W-1:0];
               OFF_CTRL_CLR: ctrl_ff[e] <= ctrl_ff[e] & ~sel_wdata[CTRL_W-1:0];
               default: ctrl_ff[e] <= ctrl_ff[e];
            endcase
         end
      end

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            cnt_ff[e] <= '0;
            wptr_ff <= '0;
            rptr_ff <= '0;
         end else if (flush) begin
            cnt_ff[e] <= '0;
            wptr_ff <= '0;
            rptr_ff <= '0;
         end else begin
            if (acc) begin
               wptr_ff <= wptr_ff + PTR_W'(1);
            end
            if (pop) begin
               rptr_ff <= rptr_ff + PTR_W'(1);
            end
            if (acc && !pop) begin
               cnt_ff[e] <= cnt_ff[e] + CNT_W'(1);
            end else if (pop && !acc) begin
               cnt_ff[e] <= cnt_ff[e] - CNT_W'(1);
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (acc) begin
            mem_ff[wptr_ff] <= din[e];
         end
      end

      // Sticky status; a new event beats the clear-on-read
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            loaded_ff[e] <= 1'b0;
            drop_ff[e] <= 1'b0;
         end else begin
            loaded_ff[e] <= acc || (loaded_ff[e] && !rc_hit);
            drop_ff[e] <= (ld[e] && !acc) || (drop_ff[e] && !rc_hit);
         end
      end
   end
endmodule

// File: dma_bypass_props.sv
// Assertions on the link between the device and supplier ends
`timescale 1ns/1ns
module dma_bypass_props #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [NUM_CH-1:0] host_to_card_bypass_ready,
   input wire logic [NUM_CH-1:0] host_to_card_bypass_load,
   input wire logic [NUM_CH-1:0] card_to_host_bypass_load,
   input wire logic reg_req_valid,
   input wire logic reg_req_bar1,
   input wire logic [31:0] reg_req_addr,
   input wire logic reg_req_write,
   input wire logic [31:0] reg_req_wdata,
   input wire logic reg_req_ready,
   input wire logic reg_rsp_valid,
   input wire logic [31:0] reg_rsp_rdata
);
   import dma_byp_pkg::*;
   logic [2*NUM_CH-1:0] any_ld;
   assign any_ld = {card_to_host_bypass_load, host_to_card_bypass_load};
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence take_s(b);
      reg_req_valid && reg_req_ready && reg_req_bar1 == b;
   endsequence
   // Only channel 0 so the ready bit index is fixed
   sequence ctl0_s(off);
      take_s(1'b1) ##0 reg_req_write && reg_req_addr[15:0] == {TGT_HTC, 4'h0, off};
   endsequence
   bar1_answer_a: assert property (take_s(1'b1) |=> reg_rsp_valid)
      else $error("internal request got no answer");
   bar0_route_a: assert property (take_s(1'b0) |=> !reg_req_ready && !reg_rsp_valid)
      else $error("user request answered internally");
   rsvd_zero_a: assert property (take_s(1'b1) ##0 !reg_req_write &&
      reg_req_addr[15:12] inside {4'h2, [4'h4:4'h8], [4'h9:4'hF]} |=> reg_rsp_rdata == '0)
      else $error("reserved target read not zero");
   word_align_a: assert property (reg_req_valid && reg_req_bar1 |-> reg_req_addr[1:0] == 2'h0)
      else $error("misaligned register address");
   chan_zero_a: assert property (reg_req_valid && reg_req_bar1 &&
      !(reg_req_addr[15:12] inside {4'h0, 4'h1, 4'h4, 4'h5}) |-> reg_req_addr[11:8] == 4'h0)
      else $error("channel field not zero");
   load_pulse_a: assert property (|any_ld |=> (any_ld & $past(any_ld)) == '0)
      else $error("load held over two cycles");
   run_stop_a: assert property (ctl0_s(OFF_CTRL) ##0 !reg_req_wdata[0] |-> ##2 !host_to_card_bypass_ready[0])
      else $error("ready without run");
   run_start_a: assert property (ctl0_s(OFF_CTRL_SET) ##0 reg_req_wdata[0] |-> ##[1:3] host_to_card_bypass_ready[0])
      else $error("run set but no ready");
endmodule

// File: dma_bypass_supplier.sv
// Supplier end: descriptor loader and host register requester
`timescale 1ns/1ns
module dma_bypass_supplier #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   dma_byp_if.supplier bif,
   input wire logic desc_valid_i,
   input wire logic desc_card_to_host_i,
   input wire logic [1:0] desc_chan_i,
   input wire dma_byp_pkg::desc_t desc_i,
   output logic desc_ready_o,
   input wire logic reg_valid_i,
   input wire logic reg_bar1_i,
   input wire logic [dma_byp_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_write_i,
   input wire logic [dma_byp_pkg::DATA_W-1:0] reg_wdata_i,
   output logic reg_ready_o,
   output logic reg_done_o,
   output logic [dma_byp_pkg::DATA_W-1:0] reg_rdata_o
);
   import dma_byp_pkg::*;

   localparam int ENG = 2*NUM_CH;

   // Aligns and clears the channel field where it selects nothing
   function automatic logic [ADDR_W-1:0] fix_addr(input logic [ADDR_W-1:0] a, input logic bar1);
      logic [3:0] t;
      fix_addr = a;
      t = a[TGT_HI:TGT_LO];
      fix_addr[1:0] = 2'b00;
      if (bar1 && t != TGT_HTC && t != TGT_CTH && t != TGT_HTC_SG && t != TGT_CTH_SG) begin
         fix_addr[CH_HI:CH_LO] = 4'h0;
      end
   endfunction

   logic [ENG-1:0] rdy;
   logic [ENG-1:0] extra_ff;
   logic [ENG-1:0] load_ff;
   desc_t desc_ff;
   int idx;
   logic issue;
   sup_st_t st_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic bar1_ff;
   logic write_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic done_ff;
   logic [DATA_W-1:0] rdata_ff;

   assign rdy = {bif.card_to_host_bypass_ready, bif.host_to_card_bypass_ready};
   assign idx = desc_card_to_host_i ? NUM_CH + int'(desc_chan_i) : int'(desc_chan_i);
   // One load in flight, so ready always reflects the last load
   assign desc_ready_o = int'(desc_chan_i) < NUM_CH && load_ff == '0 && (rdy[idx] || extra_ff[idx]);
   assign issue = desc_valid_i && desc_ready_o;

   for (genvar e = 0; e < ENG; e++) begin : g_allow
      // one extra load after ready falls
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            extra_ff[e] <= 1'b0;
            load_ff[e] <= 1'b0;
         end else begin
            extra_ff[e] <= rdy[e] || (extra_ff[e] && !(issue && idx == e));
            load_ff[e] <= issue && idx == e;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         desc_ff <= '0;
      end else if (issue) begin
         desc_ff <= desc_i;
      end
   end

   assign bif.host_to_card_bypass_load = load_ff[NUM_CH-1:0];
   assign bif.card_to_host_bypass_load = load_ff[ENG-1:NUM_CH];
   for (genvar c = 0; c < NUM_CH; c++) begin : g_fields
      assign bif.host_to_card_bypass_source_address[c] = desc_ff.src;
      assign bif.host_to_card_bypass_dest_address[c] = desc_ff.dst;
      assign bif.card_to_host_bypass_source_address[c] = desc_ff.src;
      assign bif.card_to_host_bypass_dest_address[c] = desc_ff.dst;
      assign bif.host_to_card_bypass_length[c] = desc_ff.len;
      assign bif.card_to_host_bypass_length[c] = desc_ff.len;
      assign bif.host_to_card_bypass_control[c] = desc_ff.ctl;
      assign bif.card_to_host_bypass_control[c] = desc_ff.ctl;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_ff <= SP_IDLE;
         addr_ff <= '0;
         bar1_ff <= 1'b0;
         write_ff <= 1'b0;
         wdata_ff <= '0;
         done_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         done_ff <= 1'b0;
         case (st_ff)
            SP_IDLE: begin
               if (reg_valid_i) begin
                  st_ff <= SP_REQ;
                  addr_ff <= fix_addr(reg_addr_i, reg_bar1_i);
                  bar1_ff <= reg_bar1_i;
                  write_ff <= reg_write_i;
                  wdata_ff <= reg_wdata_i;
               end
            end
            SP_REQ: begin
               if (bif.reg_req_ready) begin
                  st_ff <= SP_WAIT;
               end
            end
            SP_WAIT: begin
               if (bif.reg_rsp_valid) begin
                  st_ff <= SP_IDLE;
                  done_ff <= 1'b1;
                  rdata_ff <= bif.reg_rsp_rdata;
               end
            end
            default: begin
               st_ff <= SP_IDLE;
            end
         endcase
      end
   end

   assign bif.reg_req_valid = (st_ff == SP_REQ);
   assign bif.reg_req_bar1 = bar1_ff;
   assign bif.reg_req_addr = addr_ff;
   assign bif.reg_req_write = write_ff;
   assign bif.reg_req_wdata = wdata_ff;
   assign reg_ready_o = (st_ff == SP_IDLE);
   assign reg_done_o = done_ff;
   assign reg_rdata_o = rdata_ff;
endmodule

// File: test_dma_desc_bypass_and_reg_decode.sv
// Self-checking bench for both ends of the bypass and register link
`timescale 1ns/1ns
module test_dma_desc_bypass_and_reg_decode;
   import dma_byp_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   desc_t eng_desc [8];
   desc_t dd = '0;
   logic [7:0] ev, erun;
   logic [7:0] er = '0;
   logic umv, umw, usr, usk, drdy, rrdy, rdn, umk = 1'b0;
   logic usv = 1'b0, usw = 1'b0, dv = 1'b0, dc = 1'b0, rv = 1'b0, rb = 1'b0, rw = 1'b0;
   logic [1:0] dch = '0;
   logic [31:0] uma, umd, usq, rq, q, q2, umr = '0, umlast = '0, usa = '0, usd = '0, ra = '0, rd = '0;
   logic [15:0] rsv [9] = '{16'h2004, 16'h3004, 16'h4004, 16'h5004, 16'h6004, 16'h7004, 16'h8004, 16'h0050, 16'h0504};
   int fails = 0, cmp_count = 0;
   dma_byp_if bif ();
   dma_bypass_device i_dma_bypass_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bif(bif), .eng_desc_o(eng_desc),
      .eng_desc_valid_o(ev), .eng_desc_ready_i(er), .eng_run_o(erun), .um_valid_o(umv), .um_addr_o(uma),
      .um_write_o(umw), .um_wdata_o(umd), .um_ack_i(umk), .um_rdata_i(umr), .us_valid_i(usv), .us_addr_i(usa),
      .us_write_i(usw), .us_wdata_i(usd), .us_ready_o(usr), .us_rsp_valid_o(usk), .us_rdata_o(usq));
   dma_bypass_supplier i_dma_bypass_supplier (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bif(bif), .desc_valid_i(dv),
      .desc_card_to_host_i(dc), .desc_chan_i(dch), .desc_i(dd), .desc_ready_o(drdy), .reg_valid_i(rv),
      .reg_bar1_i(rb), .reg_addr_i(ra), .reg_write_i(rw), .reg_wdata_i(rd), .reg_ready_o(rrdy),
      .reg_done_o(rdn), .reg_rdata_o(rq));
   dma_bypass_props i_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .host_to_card_bypass_ready(bif.host_to_card_bypass_ready), .host_to_card_bypass_load(bif.host_to_card_bypass_load),
      .card_to_host_bypass_load(bif.card_to_host_bypass_load), .reg_req_valid(bif.reg_req_valid),
      .reg_req_bar1(bif.reg_req_bar1), .reg_req_addr(bif.reg_req_addr), .reg_req_write(bif.reg_req_write),
      .reg_req_wdata(bif.reg_req_wdata), .reg_req_ready(bif.reg_req_ready), .reg_rsp_valid(bif.reg_rsp_valid),
      .reg_rsp_rdata(bif.reg_rsp_rdata));
   always #20 clk_i = ~clk_i;
   // User register target: answers one cycle late, data derived from address
   always @(posedge clk_i) begin
      umk <= umv && !umk;
      umr <= ~uma;
      if (umv && umw) umlast <= umd;
   end
   task automatic summarize();
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [191:0] e, input logic [191:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bump(inout int n);
      n++;
      if (n > 99) begin
         fails++;
         summarize();
      end
   endtask
   function automatic desc_t mk(input logic [7:0] k);
      mk = '{src: {k, 48'h0, ~k}, dst: {8{k}}, len: {k[3:0], 16'h0, k}, ctl: {k, ~k}};
   endfunction
   task automatic reg_io(input logic b, input logic [31:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] v);
      int n = 0;
      @(posedge clk_i);
      rv <= 1'b1;
      rb <= b;
      ra <= a;
      rw <= w;
      rd <= d;
      do begin @(negedge clk_i); bump(n); end while (!rrdy);
      @(posedge clk_i);
      rv <= 1'b0;
      do begin @(negedge clk_i); bump(n); end while (!rdn);
      v = rq;
   endtask
   task automatic us_io(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] v);
      int n = 0;
      @(posedge clk_i);
      usv <= 1'b1;
      usa <= a;
      usw <= w;
      usd <= d;
      do begin @(negedge clk_i); bump(n); end while (!usr);
      @(posedge clk_i);
      usv <= 1'b0;
      do begin @(negedge clk_i); bump(n); end while (!usk);
      v = usq;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] v;
      reg_io(1'b1, a, 1'b0, '0, v);
      chk("reg_rdata", e, v);
   endtask
   task automatic wr(input logic b, input logic [31:0] a, input logic [31:0] d);
      logic [31:0] v;
      reg_io(b, a, 1'b1, d, v);
   endtask
   task automatic ld(input logic c, input logic [1:0] ch, input desc_t x);
      int n = 0;
      @(posedge clk_i);
      dv <= 1'b1;
      dc <= c;
      dch <= ch;
      dd <= x;
      do begin @(negedge clk_i); bump(n); end while (!drdy);
      @(posedge clk_i);
      dv <= 1'b0;
   endtask
   // Engine side stalls except for the single pop cycle
   task automatic pop(input int e, input logic [7:0] k);
      @(negedge clk_i);
      chk("eng_valid", 1'b1, ev[e]);
      chk("eng_desc", mk(k), eng_desc[e]);
      @(posedge clk_i);
      er[e] <= 1'b1;
      @(posedge clk_i);
      er[e] <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rchk(32'h0000_1200, {ID_CODE, TGT_CTH, 4'h0, 4'h2, ID_VER});
      rchk(32'hABCD_0300, {ID_CODE, TGT_HTC, 4'h0, 4'h3, ID_VER});
      chk("ready", '0, {bif.card_to_host_bypass_ready, bif.host_to_card_bypass_ready});
      rchk(32'h0000_0204, '0);
      wr(1'b1, 32'h0000_0204, 32'hFFFF_FFFE);
      rchk(32'h0000_0204, 32'h07FF_FFFE);
      wr(1'b1, 32'h0000_020C, 32'h0000_00F0);
      rchk(32'h0000_020C, 32'h07FF_FF0E);
      wr(1'b1, 32'h0000_0208, 32'h0000_0001);
      rchk(32'h0000_0204, 32'h07FF_FF0F);
      rchk(32'h0000_0214, '0);
      wr(1'b1, 32'h0000_0204, '0);
      // Leftover allowance sends a load to a stopped channel
      ld(1'b0, 2'd2, mk(8'h0B));
      rchk(32'h0000_0240, 32'h0000_0002);
      wr(1'b1, 32'h0000_0008, 32'h0000_0001);
      wr(1'b1, 32'h0000_1104, 32'h0000_0001);
      for (int k = 1; k <= 4; k++) ld(1'b0, 2'd0, mk(8'(k)));
      ld(1'b1, 2'd1, mk(8'h09));
      ld(1'b1, 2'd1, mk(8'h0A));
      rchk(32'h0000_0040, 32'h0000_0401);
      chk("ready", 1'b0, bif.host_to_card_bypass_ready[0]);
      rchk(32'h0000_0044, 32'h0000_0401);
      rchk(32'h0000_0040, 32'h0000_0400);
      rchk(32'h0000_3000, 32'h0000_0021);
      chk("run", 8'h21, erun);
      for (int k = 1; k <= 4; k++) pop(0, 8'(k));
      pop(5, 8'h09);
      pop(5, 8'h0A);
      ld(1'b0, 2'd0, mk(8'h05));
      wr(1'b1, 32'h0000_0004, '0);
      rchk(32'h0000_0040, 32'h0000_0101);
      chk("eng_valid", 1'b0, ev[0]);
      foreach (rsv[i]) begin
         wr(1'b1, {16'h0, rsv[i]}, '1);
         rchk({16'h0, rsv[i]}, '0);
      end
      wr(1'b0, 32'h1234_5678, 32'hCAFE_0001);
      chk("user_wdata", 32'hCAFE_0001, umlast);
      reg_io(1'b0, 32'h0000_0ABC, 1'b0, '0, q);
      chk("user_rdata", 32'hFFFF_F543, q);
      // Slave request raised while the host request is pending
      fork
         begin
            @(posedge clk_i);
            us_io(32'h0000_0304, 1'b1, 32'h0000_0F00, q2);
         end
         begin
            repeat (2) @(negedge clk_i);
            chk("slave_ready", 1'b0, usr);
         end
         rchk(32'h0000_0300, {ID_CODE, TGT_HTC, 4'h0, 4'h3, ID_VER});
      join
      us_io(32'h0000_0304, 1'b0, '0, q2);
      chk("slave_rdata", 32'h0000_0F00, q2);
      summarize();
   end
endmodule
